/* common/srf_pkg.sv */
// package: constants and types for the safety relay fault diagnostic block
package srf_pkg;
   localparam int NUM_CH          = 12;
   localparam int STAT_W          = 32;
   localparam int NEG_LSB         = 0;
   localparam int POS_LSB         = 12;
   localparam int BIT_RESTART     = 24;
   localparam int BIT_FEEDBACK    = 25;
   localparam int BIT_RELAY       = 26;
   localparam int BIT_SUPPLY_OK   = 27;
   localparam int UNUSED_LSB      = 28;
   localparam int UNUSED_W        = 4;
   localparam logic [STAT_W-1:0] STATUS_RST = 32'h00000000;
   // indicator codes {run, err, io}
   localparam logic [2:0] IND_NORMAL    = 3'h4;
   localparam logic [2:0] IND_INOPER    = 3'h2;
   localparam logic [2:0] IND_SUPPLY    = 3'h1;
   localparam logic [2:0] IND_UNDERVOLT = 3'h5;
   localparam logic [2:0] IND_INTERNAL  = 3'h6;
   localparam logic [2:0] IND_GENERAL   = 3'h7;
   // fault classes
   typedef enum logic [1:0]
   {
      SRF_FLT_NONE     = 2'h0,
      SRF_FLT_EXTERNAL = 2'h1,
      SRF_FLT_INTERNAL = 2'h3,
      SRF_FLT_OTHER    = 2'h2
   } srf_fault_class_e;
   // relay control states, gray coded along idle -> armed -> closed
   typedef enum logic [1:0]
   {
      SRF_ST_OPEN    = 2'h0,
      SRF_ST_READY   = 2'h1,
      SRF_ST_CLOSED  = 2'h3,
      SRF_ST_LOCKED  = 2'h2
   } srf_state_e;
endpackage : srf_pkg

/* verilog/srf_sync.sv */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module srf_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // data
   input  wire logic [WIDTH-1:0] d_i,
   output var  logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;

   // refused while elaborating, before any logic is built
   if (WIDTH < 1)
   begin : g_bad_width
      $error("srf_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_r <= '0;
         q_o    <= '0;
      end
      else
      begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : srf_sync
`default_nettype wire

/* verilog/srf_safety_diag.sv */
// safety relay fault detection, lockout and diagnostic status vector
//
// Overview of operation
// - inter-channel short clears status bit 27 to signal a fault
// - double-contact mismatch on activated device opens outputs and locks out reactivation
// - no reactivation while the feedback loop is open
// - internal failure opens relays at next activation or supply trip, never closes again
// - current-limit trip drives bit 27 low and flags a fault
// - external supply loss opens outputs at once and flags a fault
// - power-up reset clears the input self-check lockout
// - consistency uses present states; matching channels drop the mismatch lockout
// - bits 0-11 negative, 12-23 positive channel contacts, set means closed
// - bit 24 set only when restart input and feedback loop both closed
// - bit 25 follows the feedback loop, set when closed
// - bit 26 set while both output relays are driven
// - bit 27 set while supply present, cleared on supply fault or short
// - bits 28-31 unused, read as zero
// - run/err/io indicators encode normal, inoperative, supply, low, internal, general
// - faults classed external (supply), internal (self-check) or other
// - channel bits keep showing real contact states during faults
// - restart only without stop request and with loop closed, edge or level
// - supply at the low threshold forces outputs open regardless of indication
`timescale 1ns/1ps
`default_nettype none
module srf_safety_diag
   import srf_pkg::*;
#(
   parameter int CHANNELS = NUM_CH
)
(
   // clock and reset
   input  wire logic                REF_CLK_I,
   input  wire logic                RESET_I,
   // channel contacts, high means closed
   input  wire logic [CHANNELS-1:0] NEG_CONTACT_I,
   input  wire logic [CHANNELS-1:0] POS_CONTACT_I,
   // wiring and restart
   input  wire logic                DOUBLE_CONTACT_MODE_I,
   input  wire logic                RESTART_CLOSED_I,
   input  wire logic                RESTART_EDGE_MODE_I,
   input  wire logic                FEEDBACK_CLOSED_I,
   // supply and self-check monitors
   input  wire logic                SUPPLY_PRESENT_I,
   input  wire logic                SUPPLY_ABOVE_LOW_I,
   input  wire logic                SUPPLY_ABOVE_WARN_I,
   input  wire logic                SUPPLY_CHECK_EN_I,
   input  wire logic                CURRENT_LIMIT_I,
   input  wire logic                CHANNEL_SHORT_I,
   input  wire logic                INTERNAL_FAULT_I,
   input  wire logic                MODULE_INOPERATIVE_I,
   // relay drive and diagnostics
   output var  logic                OUTPUT_RELAY_A_O,
   output var  logic                OUTPUT_RELAY_B_O,
   output var  logic [STAT_W-1:0]   STATUS_O,
   output var  logic                RUN_LED_O,
   output var  logic                ERR_LED_O,
   output var  logic                IO_LED_O,
   output var  logic [1:0]          FAULT_CLASS_O,
   output var  logic                LOCKOUT_O
);
   // refused while elaborating: the status layout has fixed bit positions
   if (CHANNELS != NUM_CH)
   begin : g_bad_channels
      $error("srf_safety_diag: status layout serves exactly twelve channels");
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronise pins
   localparam int MISC_W = 12;
   logic [CHANNELS-1:0] neg_s;
   logic [CHANNELS-1:0] pos_s;
   logic [MISC_W-1:0]   misc_s;

   srf_sync #(.WIDTH(CHANNELS)) u_sync_neg
   (
      .clk_i (REF_CLK_I),
      .rst_i (RESET_I),
      .d_i   (NEG_CONTACT_I),
      .q_o   (neg_s)
   );

   srf_sync #(.WIDTH(CHANNELS)) u_sync_pos
   (
      .clk_i (REF_CLK_I),
      .rst_i (RESET_I),
      .d_i   (POS_CONTACT_I),
      .q_o   (pos_s)
   );

   srf_sync #(.WIDTH(MISC_W)) u_sync_misc
   (
      .clk_i (REF_CLK_I),
      .rst_i (RESET_I),
      .d_i   ({DOUBLE_CONTACT_MODE_I, RESTART_CLOSED_I, RESTART_EDGE_MODE_I,
               FEEDBACK_CLOSED_I, SUPPLY_PRESENT_I, SUPPLY_ABOVE_LOW_I,
               SUPPLY_ABOVE_WARN_I, SUPPLY_CHECK_EN_I, CURRENT_LIMIT_I,
               CHANNEL_SHORT_I, INTERNAL_FAULT_I, MODULE_INOPERATIVE_I}),
      .q_o   (misc_s)
   );

   logic dbl_s;
   logic rst_cl_s;
   logic edge_mode_s;
   logic fb_s;
   logic sup_s;
   logic sup_low_ok_s;
   logic sup_warn_ok_s;
   logic sup_chk_s;
   logic ilim_s;
   logic short_s;
   logic int_s;
   logic inop_s;

   assign {dbl_s, rst_cl_s, edge_mode_s, fb_s, sup_s, sup_low_ok_s,
           sup_warn_ok_s, sup_chk_s, ilim_s, short_s, int_s, inop_s} = misc_s;

   ////////////////////////////////////////////////////////////////////////////
   // stop request and consistency check

   // a channel pair is activated when its negative contact opens, or either contact in double-contact mode
   function automatic logic any_open(input logic [CHANNELS-1:0] n,
                                     input logic [CHANNELS-1:0] p,
                                     input logic dbl);
      any_open = dbl ? (~&n | ~&p) : ~&n;
   endfunction : any_open

   logic stop_req;
   logic mismatch;
   assign stop_req = any_open(neg_s, pos_s, dbl_s);
   // only present states compared; opening the device's other contact restores agreement
   assign mismatch = dbl_s && (neg_s != pos_s);

   // outputs must drop immediately on these, without waiting for the fsm
   logic supply_trip;
   assign supply_trip = !sup_s || !sup_low_ok_s || ilim_s;

   ////////////////////////////////////////////////////////////////////////////
   // self-check lockout (cleared only by power-up reset, matched channels or single-contact mode)
   logic check_lock_r;

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         check_lock_r <= 1'b0;
      end
      else if (mismatch && stop_req)
      begin
         check_lock_r <= 1'b1;
      end
      else if (!mismatch)
      begin
         check_lock_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // permanent internal-fault latch, only a power cycle clears it
   logic int_latch_r;

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         int_latch_r <= 1'b0;
      end
      else if (int_s || ilim_s)
      begin
         int_latch_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // restart edge detect on the synchronised level
   logic rst_cl_d_r;

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         rst_cl_d_r <= 1'b0;
      end
      else
      begin
         rst_cl_d_r <= rst_cl_s;
      end
   end

   // falling edge = button released after press
   logic restart_req;
   assign restart_req = edge_mode_s ? (rst_cl_d_r && !rst_cl_s) : rst_cl_s;

   logic restart_ok;
   assign restart_ok = restart_req && fb_s && !stop_req && !check_lock_r
                       && !int_latch_r && !supply_trip;

   ////////////////////////////////////////////////////////////////////////////
   // relay control state machine
   srf_state_e state_r;

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         state_r <= SRF_ST_OPEN;
      end
      else
      begin
         case (state_r)
            SRF_ST_OPEN:
            begin
               if (int_latch_r)
               begin
                  state_r <= SRF_ST_LOCKED;
               end
               else if (!stop_req && fb_s && !check_lock_r)
               begin
                  state_r <= SRF_ST_READY;
               end
            end
            SRF_ST_READY:
            begin
               if (int_latch_r)
               begin
                  state_r <= SRF_ST_LOCKED;
               end
               else if (stop_req || !fb_s || check_lock_r || supply_trip)
               begin
                  state_r <= SRF_ST_OPEN;
               end
               else if (restart_ok)
               begin
                  state_r <= SRF_ST_CLOSED;
               end
            end
            SRF_ST_CLOSED:
            begin
               // an internal fault waits for the next activation unless supply trips
               if (stop_req || supply_trip || check_lock_r)
               begin
                  state_r <= int_latch_r ? SRF_ST_LOCKED : SRF_ST_OPEN;
               end
            end
            SRF_ST_LOCKED:
            begin
               state_r <= SRF_ST_LOCKED;
            end
            default:
            begin
               state_r <= SRF_ST_OPEN;
            end
         endcase
      end
   end

   // drive gated combinationally too, so a supply trip opens one edge after the sync delay
   logic relay_drive;
   assign relay_drive = (state_r == SRF_ST_CLOSED) && !supply_trip && !check_lock_r;

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         OUTPUT_RELAY_A_O <= 1'b0;
         OUTPUT_RELAY_B_O <= 1'b0;
      end
      else
      begin
         OUTPUT_RELAY_A_O <= relay_drive;
         OUTPUT_RELAY_B_O <= relay_drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status vector, registered each cycle
   logic [STAT_W-1:0] status_nxt;

   always_comb
   begin
      status_nxt = STATUS_RST;
      status_nxt[NEG_LSB +: NUM_CH] = neg_s;
      status_nxt[POS_LSB +: NUM_CH] = pos_s;
      status_nxt[BIT_RESTART]       = rst_cl_s && fb_s;
      status_nxt[BIT_FEEDBACK]      = fb_s;
      status_nxt[BIT_RELAY]         = relay_drive;
      status_nxt[BIT_SUPPLY_OK]     = sup_s && !short_s && !ilim_s;
      status_nxt[UNUSED_LSB +: UNUSED_W] = '0;
   end

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         STATUS_O <= STATUS_RST;
      end
      else
      begin
         STATUS_O <= status_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault classes and module indicators
   logic ext_fault;
   logic low_warn;
   logic internal_f;
   logic general_f;
   srf_fault_class_e class_nxt;
   logic [2:0] ind_nxt;

   // without supply surveillance enabled, supply faults are not indicated
   assign ext_fault  = sup_chk_s && !sup_s;
   assign low_warn   = sup_chk_s && sup_s && !sup_warn_ok_s;
   assign internal_f = int_latch_r || check_lock_r;
   assign general_f  = short_s || ilim_s;

   always_comb
   begin
      class_nxt = SRF_FLT_NONE;
      ind_nxt   = IND_NORMAL;
      if (general_f)
      begin
         class_nxt = SRF_FLT_OTHER;
         ind_nxt   = IND_GENERAL;
      end
      else if (inop_s)
      begin
         class_nxt = SRF_FLT_INTERNAL;
         ind_nxt   = IND_INOPER;
      end
      else if (internal_f)
      begin
         class_nxt = SRF_FLT_INTERNAL;
         ind_nxt   = IND_INTERNAL;
      end
      else if (ext_fault)
      begin
         class_nxt = SRF_FLT_EXTERNAL;
         ind_nxt   = IND_SUPPLY;
      end
      else if (low_warn)
      begin
         class_nxt = SRF_FLT_EXTERNAL;
         ind_nxt   = IND_UNDERVOLT;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         RUN_LED_O     <= 1'b0;
         ERR_LED_O     <= 1'b0;
         IO_LED_O      <= 1'b0;
         FAULT_CLASS_O <= SRF_FLT_NONE;
         LOCKOUT_O     <= 1'b0;
      end
      else
      begin
         {RUN_LED_O, ERR_LED_O, IO_LED_O} <= ind_nxt;
         FAULT_CLASS_O <= class_nxt;
         LOCKOUT_O     <= check_lock_r || int_latch_r;
      end
   end
endmodule : srf_safety_diag
`default_nettype wire

/* verif/srf_safety_diag_properties.sv */
// concurrent checks on the ports of the safety relay diagnostic block
`timescale 1ns/1ps
`default_nettype none
module srf_safety_diag_props
   import srf_pkg::*;
#(
   parameter int CHANNELS = NUM_CH
)
(
   // clock and reset
   input wire logic                REF_CLK_I,
   input wire logic                RESET_I,
   // watched inputs
   input wire logic [CHANNELS-1:0] NEG_CONTACT_I,
   input wire logic [CHANNELS-1:0] POS_CONTACT_I,
   input wire logic                RESTART_CLOSED_I,
   input wire logic                FEEDBACK_CLOSED_I,
   input wire logic                SUPPLY_PRESENT_I,
   input wire logic                SUPPLY_ABOVE_LOW_I,
   input wire logic                CURRENT_LIMIT_I,
   input wire logic                CHANNEL_SHORT_I,
   // watched outputs
   input wire logic                OUTPUT_RELAY_A_O,
   input wire logic                OUTPUT_RELAY_B_O,
   input wire logic [STAT_W-1:0]   STATUS_O,
   input wire logic                LOCKOUT_O
);
   logic [2:0] age_r;
   logic       ilim_r;
   logic       ok_w;
   logic       trip_w;
   ////////////////////////////////////////////////////////////////////////////
   // $past reaches three edges back, so wait until those edges follow reset
   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         age_r <= 3'h0;
      else if (age_r != 3'h7)
         age_r <= age_r + 3'h1;
   end
   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         ilim_r <= 1'h0;
      else if (CURRENT_LIMIT_I)
         ilim_r <= 1'h1;
   end
   assign ok_w   = (age_r == 3'h7);
   assign trip_w = !SUPPLY_PRESENT_I || !SUPPLY_ABOVE_LOW_I || CURRENT_LIMIT_I;
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   a_unused_bits_zero: assert property (STATUS_O[31:28] == 4'h0)
      else $error("spare status bits set");
   a_contact_bits_track: assert property (ok_w |-> STATUS_O[23:0] ==
      {$past(POS_CONTACT_I, 3), $past(NEG_CONTACT_I, 3)})
      else $error("contact bits differ from pins");
   a_feedback_bit_tracks: assert property (ok_w |->
      STATUS_O[BIT_FEEDBACK] == $past(FEEDBACK_CLOSED_I, 3))
      else $error("feedback bit wrong");
   a_restart_bit_and: assert property (ok_w |-> STATUS_O[BIT_RESTART] ==
      ($past(RESTART_CLOSED_I, 3) && $past(FEEDBACK_CLOSED_I, 3)))
      else $error("restart bit wrong");
   a_supply_bit_tracks: assert property (ok_w |-> STATUS_O[BIT_SUPPLY_OK] ==
      ($past(SUPPLY_PRESENT_I, 3) && !$past(CHANNEL_SHORT_I, 3) && !$past(CURRENT_LIMIT_I, 3)))
      else $error("supply ok bit wrong");
   a_relay_pair_match: assert property ((OUTPUT_RELAY_A_O == OUTPUT_RELAY_B_O) &&
      (STATUS_O[BIT_RELAY] == OUTPUT_RELAY_A_O))
      else $error("relay drives or relay bit disagree");
   a_supply_trip_opens: assert property (ok_w && $past(trip_w, 3) |-> !OUTPUT_RELAY_A_O)
      else $error("relay driven during supply trip");
   a_limit_never_closes: assert property ($past(ilim_r, 3) |-> !OUTPUT_RELAY_A_O)
      else $error("relay driven after current limit");
   a_close_needs_ready: assert property ($rose(OUTPUT_RELAY_A_O) |->
      (($past(STATUS_O) & 32'h02000FFF) == 32'h02000FFF) && !$past(LOCKOUT_O))
      else $error("relay closed without restart conditions");
endmodule : srf_safety_diag_props
bind srf_safety_diag srf_safety_diag_props #(.CHANNELS(CHANNELS)) u_props
(
   .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .NEG_CONTACT_I(NEG_CONTACT_I),
   .POS_CONTACT_I(POS_CONTACT_I), .RESTART_CLOSED_I(RESTART_CLOSED_I),
   .FEEDBACK_CLOSED_I(FEEDBACK_CLOSED_I), .SUPPLY_PRESENT_I(SUPPLY_PRESENT_I),
   .SUPPLY_ABOVE_LOW_I(SUPPLY_ABOVE_LOW_I), .CURRENT_LIMIT_I(CURRENT_LIMIT_I),
   .CHANNEL_SHORT_I(CHANNEL_SHORT_I), .OUTPUT_RELAY_A_O(OUTPUT_RELAY_A_O),
   .OUTPUT_RELAY_B_O(OUTPUT_RELAY_B_O), .STATUS_O(STATUS_O), .LOCKOUT_O(LOCKOUT_O)
);
`default_nettype wire

/* verif/srf_host_model.sv */
// host side model: takes one status snapshot per read request
`timescale 1ns/1ps
`default_nettype none
module srf_host_model
   import srf_pkg::*;
(
   // clock
   input  wire logic              clk_i,
   // read request and result
   input  wire logic              rd_i,
   input  wire logic [STAT_W-1:0] status_i,
   output var  logic [STAT_W-1:0] rd_data_o
);
   // whole vector taken on one edge so bits never mix two cycles
   always_ff @(posedge clk_i)
   begin
      if (rd_i)
         rd_data_o <= status_i;
   end
endmodule : srf_host_model
`default_nettype wire

/* verif/srf_safety_diag_tb.sv */
// self-checking testbench for the safety relay diagnostic block
`timescale 1ns/1ps
`default_nettype none
module srf_safety_diag_tb;
   import srf_pkg::*;
   logic        clk = 1'h0, rst = 1'h1, rd = 1'h0;
   logic [11:0] neg = 12'hFFF, pos = 12'hFFF;
   logic        dbl = 1'h0, rs = 1'h0, edg = 1'h0, fb = 1'h1;
   logic        sp = 1'h1, slow = 1'h1, swarn = 1'h1, sen = 1'h1;
   logic        ilim = 1'h0, shrt = 1'h0, intf = 1'h0, inop = 1'h0;
   logic        rla, rlb, run, err, io, lck;
   logic [1:0]  cls;
   logic [31:0] st, hst;
   int          n_mismatch = 0, compares = 0;
   always #20 clk = ~clk;
   srf_safety_diag uut
   (
      .REF_CLK_I(clk), .RESET_I(rst), .NEG_CONTACT_I(neg), .POS_CONTACT_I(pos),
      .DOUBLE_CONTACT_MODE_I(dbl), .RESTART_CLOSED_I(rs), .RESTART_EDGE_MODE_I(edg),
      .FEEDBACK_CLOSED_I(fb), .SUPPLY_PRESENT_I(sp), .SUPPLY_ABOVE_LOW_I(slow),
      .SUPPLY_ABOVE_WARN_I(swarn), .SUPPLY_CHECK_EN_I(sen), .CURRENT_LIMIT_I(ilim),
      .CHANNEL_SHORT_I(shrt), .INTERNAL_FAULT_I(intf), .MODULE_INOPERATIVE_I(inop),
      .OUTPUT_RELAY_A_O(rla), .OUTPUT_RELAY_B_O(rlb), .STATUS_O(st), .RUN_LED_O(run),
      .ERR_LED_O(err), .IO_LED_O(io), .FAULT_CLASS_O(cls), .LOCKOUT_O(lck)
   );
   srf_host_model host (.clk_i(clk), .rd_i(rd), .status_i(st), .rd_data_o(hst));
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic chk1(input logic seen, input logic exp);
      chk({31'h0, seen}, {31'h0, exp});
   endtask : chk1
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic rd_st(input logic [31:0] exp);
      rd = 1'h1;
      cyc(1);
      rd = 1'h0;
      chk(hst, exp);
   endtask : rd_st
   task automatic led(input logic [2:0] exp);
      chk({29'h0, run, err, io}, {29'h0, exp});
   endtask : led
   // bounded wait for the relay drive to reach a level
   task automatic wrel(input logic exp);
      int i;
      for (i = 0; i < 12 && rla !== exp; i++)
         cyc(1);
      chk1(rla, exp);
      if (rla !== exp)
         print_verdict();
   endtask : wrel
   task automatic pulse;
      rs = 1'h1;
      cyc(2);
      rs = 1'h0;
   endtask : pulse
   // one stop device at a time, opened until the relays drop, then closed
   task automatic trip(input int i);
      neg[i] = 1'h0;
      wrel(1'h0);
      neg[i] = 1'h1;
   endtask : trip
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(1);
      chk(st, 32'h0);
      cyc(1);
      rst = 1'h0;
      cyc(5);
      rd_st(32'h0AFFFFFF);
      led(IND_NORMAL);
      chk({30'h0, cls}, {30'h0, SRF_FLT_NONE});
      rs = 1'h1;
      wrel(1'h1);
      chk1(rlb, 1'h1);
      rd_st(32'h0FFFFFFF);
      rs = 1'h0;
      neg[5] = 1'h0;
      wrel(1'h0);
      chk1(rlb, 1'h0);
      cyc(2);
      rd_st(32'h0AFFFFDF);
      rs = 1'h1;
      cyc(8);
      chk1(rla, 1'h0);
      neg[5] = 1'h1;
      wrel(1'h1);
      rs = 1'h0;
      trip(2);
      fb = 1'h0;
      rs = 1'h1;
      cyc(8);
      chk1(rla, 1'h0);
      rd_st(32'h08FFFFFF);
      fb = 1'h1;
      wrel(1'h1);
      rs = 1'h0;
      edg = 1'h1;
      trip(0);
      rs = 1'h1;
      cyc(8);
      chk1(rla, 1'h0);
      rs = 1'h0;
      wrel(1'h1);
      dbl = 1'h1;
      cyc(4);
      neg[3] = 1'h0;
      wrel(1'h0);
      cyc(2);
      chk1(lck, 1'h1);
      pulse();
      cyc(8);
      chk1(rla, 1'h0);
      pos[3] = 1'h0;
      cyc(5);
      chk1(lck, 1'h0);
      pos[3] = 1'h1;
      neg[3] = 1'h1;
      pulse();
      wrel(1'h1);
      sp = 1'h0;
      wrel(1'h0);
      cyc(2);
      chk1(st[BIT_SUPPLY_OK], 1'h0);
      led(IND_SUPPLY);
      chk({30'h0, cls}, {30'h0, SRF_FLT_EXTERNAL});
      sen = 1'h0;
      cyc(4);
      led(IND_NORMAL);
      sen = 1'h1;
      sp = 1'h1;
      swarn = 1'h0;
      cyc(5);
      led(IND_UNDERVOLT);
      swarn = 1'h1;
      pulse();
      wrel(1'h1);
      slow = 1'h0;
      wrel(1'h0);
      slow = 1'h1;
      shrt = 1'h1;
      cyc(5);
      chk1(st[BIT_SUPPLY_OK], 1'h0);
      led(IND_GENERAL);
      chk({30'h0, cls}, {30'h0, SRF_FLT_OTHER});
      shrt = 1'h0;
      inop = 1'h1;
      cyc(5);
      led(IND_INOPER);
      inop = 1'h0;
      pulse();
      wrel(1'h1);
      intf = 1'h1;
      cyc(5);
      led(IND_INTERNAL);
      chk({30'h0, cls}, {30'h0, SRF_FLT_INTERNAL});
      trip(1);
      pulse();
      cyc(10);
      chk1(rla, 1'h0);
      chk1(lck, 1'h1);
      intf = 1'h0;
      pulse();
      cyc(10);
      chk1(rla, 1'h0);
      ilim = 1'h1;
      cyc(5);
      chk1(st[BIT_SUPPLY_OK], 1'h0);
      ilim = 1'h0;
      rst = 1'h1;
      cyc(2);
      chk(st, 32'h0);
      chk1(rla, 1'h0);
      rst = 1'h0;
      cyc(5);
      chk1(lck, 1'h0);
      pulse();
      wrel(1'h1);
      print_verdict();
   end
endmodule : srf_safety_diag_tb
`default_nettype wire
